// *** hw/cio_pkg.sv ***
// Purpose: shared constants for the controller i/o strobe decoder
// Assumes: processor bus sampled on clk, E clock arrives as a plain input
// Notes: decoder line numbers name the strobe use, not a pin
package cio_pkg;
	// processor address decode
	localparam logic [2:0] IO_SEL_INPUT = 3'h6;
	localparam logic [2:0] IO_SEL_ADAPTER = 3'h4;
	localparam logic [2:0] RAM_SEL_WORK = 3'h0;
	localparam logic [2:0] RAM_SEL_STORE = 3'h1;
	localparam int ADDR_IO_MSB = 15;
	localparam int ADDR_ADAPTER_EN = 11;
	// adapter register choice on address bits 1..0
	localparam logic [1:0] PORT_A = 2'h0;
	localparam logic [1:0] PORT_B = 2'h1;
	localparam logic [1:0] PORT_STATUS = 2'h2;
	// port b fields
	localparam int BANK_BIT = 3;
	// steering latch fields
	localparam int STEER_OPT_BIT = 6;
	localparam int STEER_SI_BIT = 0;
	// second decoder line uses
	localparam logic [2:0] LN_DISP = 3'h0;
	localparam logic [2:0] LN_LOOP = 3'h1;
	localparam logic [2:0] LN_SHIFT = 3'h2;
	localparam logic [2:0] LN_GCLK = 3'h3;
	localparam logic [2:0] LN_FIV = 3'h4;
	localparam logic [2:0] LN_FDC = 3'h5;
	localparam logic [2:0] LN_LOAD = 3'h6;
	localparam logic [2:0] LN_STEER = 3'h7;
	// first decoder indicator lines are 3..6
	localparam logic [2:0] LN_IND_FIRST = 3'h3;
	localparam logic [2:0] LN_IND_LAST = 3'h6;
	// interrupt status word bits
	localparam int STAT_TIMER_BIT = 0;
	localparam int STAT_BUS_BIT = 1;
	// reset values
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [7:0] STROBE_IDLE = 8'hFF;
	// display scan: digits plus key lamp groups
	localparam int SCAN_LEN = 19;
	// refresh timer
	localparam int CLK_HZ = 20_000_000;
	localparam int TIMER_HZ = 1900;
	localparam int TIMER_CYCLES = CLK_HZ / TIMER_HZ;
	// strobe sequencer
	typedef enum logic [1:0] {
		CIO_IDLE = 2'b00,
		CIO_ARMED = 2'b01,
		CIO_FIRE = 2'b10
	} cio_strobe_e;
endpackage

// *** hw/cio_strobe_decoder.sv ***
// Purpose: controller i/o decode, adapter ports, output strobes, interrupts
// Assumes: all inputs but arst_n synchronous to clk; E high is the transfer phase
// Notes: strobes run one E low phase; outputs are registered
// How it works
// - ram pair: work ram and battery ram for stored setups
// - ram write while write enable low
// - read with input select strobes multiplexers
// - write with adapter select loads port
// - adapter needs address 11 high, E times
// - eight groups, low and high nibble selectors
// - config switch readable via input multiplexers
// - next E low pulses chosen decoder line
// - lines 1 and 7 latch port A
// - load shifter, shift eight, option clocks
// - general clock gated by steering latch
// - lines 4,5 drive function logic controls
// - line 0 clocks display, resets timer
// - first bank 3..6 latch indicator groups
// - bus board interrupt drives request B low
// - 1900 Hz timer drives request A low
// - status word names interrupt source
// - scan refresh digits and five lamp groups
// - indicator lamps static until relatched
// - first segment latched, single high starts
// - each display clock moves lit digit
`timescale 1ns/1ps
module cio_strobe_decoder
	import cio_pkg::*;
#(
	parameter int TIMER_PERIOD = TIMER_CYCLES
) (
	input wire logic clk, // 20 MHz system clock
	input wire logic arst_n, // async reset, active low
	input wire logic e_clk, // processor E clock, high = transfer
	input wire logic cpu_rw, // high read, low write
	input wire logic [15:0] cpu_addr, // processor address
	input wire logic [7:0] cpu_data_in, // processor write data
	output logic [7:0] cpu_data_out, // read data to processor
	output logic cpu_data_oe, // high while driving data bus
	input wire logic [27:0] mux_lo_in, // low nibbles, groups 0..6
	input wire logic [11:0] mux_hi_in, // high nibbles, entries 0..2
	input wire logic [7:0] cfg_switch, // configuration switch
	input wire logic bus_int, // bus board interrupt, high
	output logic [1:0] ram_we_n, // work / stored setup ram write
	output logic adapter_select_low_n, // adapter select, low
	output logic irq_a_n, // timer interrupt request, low
	output logic irq_b_n, // bus interrupt request, low
	output logic [7:0] dec0_n, // first bank strobes, low
	output logic [7:0] dec1_n, // second bank strobes, low
	output logic option_shift_clock_n, // gated option clock, low
	output logic serial_out, // shifter serial data
	output logic [7:0] loop_latch, // line 1 latch
	output logic [7:0] steer_latch, // line 7 steering latch
	output logic [31:0] indicator_lamps, // four static groups
	output logic [7:0] disp_segments, // current digit segments
	output logic [SCAN_LEN-1:0] disp_scan // one-hot lit position
);

////////////////////////////////////////////////////////////////
// reset release through two flops
logic rst_meta;
logic rst_n;

always_ff @(posedge clk or negedge arst_n) begin
	if (!arst_n) begin
		rst_meta <= 1'b0;
		rst_n <= 1'b0;
	end else begin
		rst_meta <= 1'b1;
		rst_n <= rst_meta;
	end
end

////////////////////////////////////////////////////////////////
// helpers
function automatic logic [7:0] onehot_n(input logic [2:0] sel);
	onehot_n = ~(8'h01 << sel);
endfunction

// low nibble from 8:1, high from dual 4:1 on bits 1..0
function automatic logic [7:0] mux_read(input logic [2:0] grp, input logic [27:0] lo,
		input logic [11:0] hi, input logic [7:0] sw);
	logic [3:0] l;
	logic [3:0] h;
	l = (grp == 3'h7) ? sw[3:0] : lo[4*grp +: 4];
	h = (grp[1:0] == 2'h3) ? sw[7:4] : hi[4*grp[1:0] +: 4];
	mux_read = {h, l};
endfunction

////////////////////////////////////////////////////////////////
// bus decode
logic e_prev;
logic e_rise;
logic e_fall;
logic io_space;
logic input_hit;
logic adapter_hit;
logic port_write;

assign e_rise = e_clk & ~e_prev;
assign e_fall = ~e_clk & e_prev;
assign io_space = ~cpu_addr[ADDR_IO_MSB];
assign input_hit = io_space & (cpu_addr[14:12] == IO_SEL_INPUT);
// adapter answers only with address 11 high
assign adapter_hit = io_space & (cpu_addr[14:12] == IO_SEL_ADAPTER) & cpu_addr[ADDR_ADAPTER_EN];
// transfer is timed by the end of the E high phase
assign port_write = e_fall & adapter_hit & ~cpu_rw;

////////////////////////////////////////////////////////////////
// bus side state
logic [7:0] port_a;
logic [7:0] port_b;
logic [7:0] next_port_a;
logic [7:0] next_port_b;
logic [7:0] next_data_out;
logic next_data_oe;
logic [1:0] next_ram_we_n;
logic next_select_n;
logic stat_timer;
logic stat_bus;
logic next_stat_timer;
logic next_stat_bus;
logic timer_pulse;
logic status_read;

always_comb begin
	next_port_a = port_a;
	next_port_b = port_b;
	if (port_write && cpu_addr[1:0] == PORT_A) begin
		next_port_a = cpu_data_in;
	end
	if (port_write && cpu_addr[1:0] == PORT_B) begin
		next_port_b = cpu_data_in;
	end
	// setups ram only on its own select code, work ram on the other
	next_ram_we_n[0] = ~(io_space & (cpu_addr[14:12] == RAM_SEL_WORK) & ~cpu_rw & e_clk);
	next_ram_we_n[1] = ~(io_space & (cpu_addr[14:12] == RAM_SEL_STORE) & ~cpu_rw & e_clk);
	next_select_n = ~(adapter_hit & e_clk);
	next_data_oe = e_clk & cpu_rw & (input_hit | adapter_hit);
	next_data_out = BYTE_RST;
	if (input_hit) begin
		next_data_out = mux_read(cpu_addr[2:0], mux_lo_in, mux_hi_in, cfg_switch);
	end else if (cpu_addr[1:0] == PORT_A) begin
		next_data_out = port_a;
	end else if (cpu_addr[1:0] == PORT_B) begin
		next_data_out = port_b;
	end else if (cpu_addr[1:0] == PORT_STATUS) begin
		next_data_out[STAT_TIMER_BIT] = stat_timer;
		next_data_out[STAT_BUS_BIT] = stat_bus;
	end
	// set wins over the clearing status read
	next_stat_timer = (stat_timer & ~status_read) | timer_pulse;
	next_stat_bus = (stat_bus & ~status_read) | bus_int;
end

assign status_read = e_fall & adapter_hit & cpu_rw & (cpu_addr[1:0] == PORT_STATUS);

always_ff @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		e_prev <= 1'b0;
		port_a <= BYTE_RST;
		port_b <= BYTE_RST;
		cpu_data_out <= BYTE_RST;
		cpu_data_oe <= 1'b0;
		ram_we_n <= 2'h3;
		adapter_select_low_n <= 1'b1;
		stat_timer <= 1'b0;
		stat_bus <= 1'b0;
		irq_a_n <= 1'b1;
		irq_b_n <= 1'b1;
	end else begin
		e_prev <= e_clk;
		port_a <= next_port_a;
		port_b <= next_port_b;
		cpu_data_out <= next_data_out;
		cpu_data_oe <= next_data_oe;
		ram_we_n <= next_ram_we_n;
		adapter_select_low_n <= next_select_n;
		stat_timer <= next_stat_timer;
		stat_bus <= next_stat_bus;
		irq_a_n <= ~next_stat_timer;
		irq_b_n <= ~next_stat_bus;
	end
end

////////////////////////////////////////////////////////////////
// strobe sequencer and its destinations
cio_strobe_e state;
cio_strobe_e next_state;
logic [7:0] next_dec0_n;
logic [7:0] next_dec1_n;
logic next_opt_n;
logic [7:0] shifter;
logic [7:0] next_shifter;
logic next_serial;
logic [7:0] next_loop;
logic [7:0] next_steer;
logic [31:0] next_lamps;
logic [7:0] next_segments;
logic [SCAN_LEN-1:0] next_scan;
logic fire;
logic [2:0] line;
logic bank_first;

assign fire = (state == CIO_ARMED) & e_fall;
assign line = port_b[2:0];
assign bank_first = port_b[BANK_BIT];

always_comb begin
	next_state = state;
	next_dec0_n = dec0_n;
	next_dec1_n = dec1_n;
	next_opt_n = option_shift_clock_n;
	next_shifter = shifter;
	next_serial = serial_out;
	next_loop = loop_latch;
	next_steer = steer_latch;
	next_lamps = indicator_lamps;
	next_segments = disp_segments;
	next_scan = disp_scan;
	case (state)
		CIO_IDLE: begin
			if (port_write && cpu_addr[1:0] == PORT_B) begin
				next_state = CIO_ARMED;
			end
		end
		CIO_ARMED: begin
			if (fire) begin
				next_state = CIO_FIRE;
				if (bank_first) begin
					next_dec0_n = onehot_n(line);
					if (line >= LN_IND_FIRST && line <= LN_IND_LAST) begin
						// lamps stay put until their own group is relatched
						next_lamps[8*(line-LN_IND_FIRST) +: 8] = port_a;
					end
				end else begin
					next_dec1_n = onehot_n(line);
					case (line)
						LN_LOOP: next_loop = port_a;
						LN_STEER: next_steer = port_a;
						LN_LOAD: next_shifter = port_a;
						LN_SHIFT: begin
							next_serial = shifter[7];
							next_shifter = {shifter[6:0], 1'b0};
						end
						LN_GCLK: next_opt_n = ~steer_latch[STEER_OPT_BIT];
						LN_DISP: begin
							// segments and scan move together so one digit is lit
							next_segments = port_a;
							next_scan = {disp_scan[SCAN_LEN-2:0], steer_latch[STEER_SI_BIT]};
						end
						default: begin
						end
					endcase
				end
			end
		end
		CIO_FIRE: begin
			if (e_rise) begin
				next_state = CIO_IDLE;
				next_dec0_n = STROBE_IDLE;
				next_dec1_n = STROBE_IDLE;
				next_opt_n = 1'b1;
			end
		end
		default: next_state = CIO_IDLE;
	endcase
end

always_ff @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		state <= CIO_IDLE;
		dec0_n <= STROBE_IDLE;
		dec1_n <= STROBE_IDLE;
		option_shift_clock_n <= 1'b1;
		shifter <= BYTE_RST;
		serial_out <= 1'b0;
		loop_latch <= BYTE_RST;
		steer_latch <= BYTE_RST;
		indicator_lamps <= '0;
		disp_segments <= BYTE_RST;
		disp_scan <= '0;
	end else begin
		state <= next_state;
		dec0_n <= next_dec0_n;
		dec1_n <= next_dec1_n;
		option_shift_clock_n <= next_opt_n;
		shifter <= next_shifter;
		serial_out <= next_serial;
		loop_latch <= next_loop;
		steer_latch <= next_steer;
		indicator_lamps <= next_lamps;
		disp_segments <= next_segments;
		disp_scan <= next_scan;
	end
end

////////////////////////////////////////////////////////////////
// refresh timer, restarted by every display clock
logic [13:0] timer_cnt;
logic [13:0] next_timer_cnt;
logic disp_clock;

assign disp_clock = fire & ~bank_first & (line == LN_DISP);
assign timer_pulse = (timer_cnt == 14'h0000);

always_comb begin
	if (disp_clock || timer_pulse) begin
		next_timer_cnt = 14'(TIMER_PERIOD - 1);
	end else begin
		next_timer_cnt = timer_cnt - 14'h0001;
	end
end

always_ff @(posedge clk or negedge rst_n) begin
	if (!rst_n) begin
		timer_cnt <= 14'h0000;
	end else begin
		timer_cnt <= next_timer_cnt;
	end
end

////////////////////////////////////////////////////////////////
// checks
default clocking cb @(posedge clk); endclocking
default disable iff (!rst_n);

input_read_a: assert property (e_clk && cpu_rw && input_hit |=> cpu_data_oe
	&& cpu_data_out == mux_read($past(cpu_addr[2:0]), $past(mux_lo_in), $past(mux_hi_in), $past(cfg_switch)))
	else $error("input read data wrong");
adapter_sel_a: assert property (adapter_select_low_n == 1'b0 |-> $past(adapter_hit && e_clk))
	else $error("adapter select without decode");
port_b_load_a: assert property (port_write && cpu_addr[1:0] == PORT_B |=> port_b == $past(cpu_data_in))
	else $error("port b not loaded");
strobe_bank_a: assert property (fire |=> (bank_first ? (dec0_n == onehot_n(line) && dec1_n == STROBE_IDLE)
	: (dec1_n == onehot_n(line) && dec0_n == STROBE_IDLE)))
	else $error("wrong decoder line pulsed");
loop_latch_a: assert property (fire && !bank_first && line == LN_LOOP |=> loop_latch == $past(port_a))
	else $error("loop latch missed port a");
opt_gate_a: assert property ($fell(option_shift_clock_n) |-> steer_latch[STEER_OPT_BIT] && dec1_n[LN_GCLK] == 1'b0)
	else $error("option clock not gated");
lamp_hold_a: assert property (!(fire && bank_first) |=> indicator_lamps == $past(indicator_lamps))
	else $error("lamps changed without latch");
// a status read may clear the flag once the board has let go, so only the next cycle is promised
bus_irq_a: assert property (bus_int |=> !irq_b_n && stat_bus)
	else $error("bus interrupt not requested");
timer_irq_a: assert property (timer_pulse |=> !irq_a_n && stat_timer)
	else $error("timer interrupt not raised");
timer_reset_a: assert property (disp_clock |=> timer_cnt == 14'(TIMER_PERIOD - 1))
	else $error("display clock did not restart timer");
// the line 4 strobe of the second bank may only start after an E fall and only end after an E rise
strobe_end_a: assert property ($changed(dec1_n[LN_FIV]) |->
	($past(dec1_n[LN_FIV]) ? $past(e_fall) : $past(e_rise)))
	else $error("strobe did not span one E low phase");
one_digit_a: assert property ($onehot0(disp_scan) |=> $onehot0(disp_scan) || $past(steer_latch[STEER_SI_BIT]))
	else $error("more than one digit lit");

cover_serial_c: cover property (fire && !bank_first && line == LN_SHIFT);
cover_lamp_c: cover property (fire && bank_first && line == LN_IND_FIRST);
cover_status_c: cover property (status_read && stat_timer && stat_bus);

endmodule

// *** sim/cio_proc_model.sv ***
// Purpose: processor side of the strobe decoder, free running E clock
// Assumes: bus cycles themselves come from the bench tasks
// Notes: E high for HALF clocks, low for HALF clocks
`timescale 1ns/1ps
module cio_proc_model #(
	parameter int HALF = 4
) (
	input wire logic clk, // system clock
	input wire logic rst_n, // bench reset, low
	output logic e_clk // processor E clock
);
	logic [7:0] cnt;
	initial e_clk = 1'b0;
	// E runs whenever reset is off: the processor clocks it with or without a bus cycle
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 8'h00;
			e_clk <= 1'b0;
		end else begin
			cnt <= (cnt == 8'(2 * HALF - 1)) ? 8'h00 : cnt + 8'h01;
			e_clk <= (cnt < 8'(HALF));
		end
	end
endmodule

// *** sim/test_controller_io_strobe_decoder.sv ***
// Purpose: self-checking bench for the controller i/o strobe decoder
// Assumes: short timer period, E from the processor model
// Notes: strobes and reads are checked by watchers against queued notes
`timescale 1ns/1ps
module test_controller_io_strobe_decoder;
	import cio_pkg::*;
	localparam int TP = 2000;
	logic clk = 1'b0, arst_n = 1'b0, cpu_rw = 1'b1, bus_int = 1'b0, e_clk;
	logic [15:0] cpu_addr = 16'h8000;
	logic [7:0] cpu_data_in = 8'h00, cfg_switch = 8'h00, cpu_data_out, dec0_n, dec1_n;
	logic [27:0] mux_lo_in = 28'h0;
	logic [11:0] mux_hi_in = 12'h0;
	logic cpu_data_oe, adapter_select_low_n, irq_a_n, irq_b_n, option_shift_clock_n, serial_out;
	logic [1:0] ram_we_n;
	logic [7:0] loop_latch, steer_latch, disp_segments, pa = 8'h00, steer = 8'h00;
	logic [31:0] indicator_lamps;
	logic [SCAN_LEN-1:0] disp_scan;
	logic [16:0] sq[$];
	logic [7:0] rq[$];
	logic oe_q = 1'b0, st_idle = 1'b1;
	int mismatches = 0, tests_run = 0, cycles = 0;
	integer seed;
	always #25 clk = ~clk;
	cio_proc_model proc (.clk(clk), .rst_n(arst_n), .e_clk(e_clk));
	cio_strobe_decoder #(.TIMER_PERIOD(TP)) uut (.clk(clk), .arst_n(arst_n), .e_clk(e_clk), .cpu_rw(cpu_rw),
		.cpu_addr(cpu_addr), .cpu_data_in(cpu_data_in), .cpu_data_out(cpu_data_out), .cpu_data_oe(cpu_data_oe),
		.mux_lo_in(mux_lo_in), .mux_hi_in(mux_hi_in), .cfg_switch(cfg_switch), .bus_int(bus_int),
		.ram_we_n(ram_we_n), .adapter_select_low_n(adapter_select_low_n), .irq_a_n(irq_a_n), .irq_b_n(irq_b_n),
		.dec0_n(dec0_n), .dec1_n(dec1_n), .option_shift_clock_n(option_shift_clock_n), .serial_out(serial_out),
		.loop_latch(loop_latch), .steer_latch(steer_latch), .indicator_lamps(indicator_lamps),
		.disp_segments(disp_segments), .disp_scan(disp_scan));
	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chk_rd(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t read=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic phase(input logic v);
		do @(posedge clk); while (e_clk !== v);
	endtask
	// write cycle: held from the low phase through the E fall that takes it
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [1:0] we;
		logic sel;
		we = 2'b00;
		sel = 1'b0;
		phase(1'b0);
		cpu_addr <= a;
		cpu_data_in <= d;
		cpu_rw <= 1'b0;
		phase(1'b1);
		do begin
			we = we | ~ram_we_n;
			sel = sel | ~adapter_select_low_n;
			@(posedge clk);
		end while (e_clk !== 1'b0);
		cpu_addr <= 16'h8000;
		cpu_rw <= 1'b1;
		cpu_data_in <= ~d; // released bus does not keep its value
		if (a == 16'h4800) pa = d;
		chk({sel, we}, {a[15:11] == 5'b01001, a[15:12] == 4'h1, a[15:12] == 4'h0});
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		phase(1'b0);
		cpu_addr <= a;
		rq.push_back(exp);
		phase(1'b1);
		phase(1'b0);
		cpu_addr <= 16'h8000;
	endtask
	// port b write, then wait out the strobe it arms
	task automatic fire(input logic bank, input logic [2:0] ln);
		logic [7:0] s;
		s = ~(8'h01 << ln);
		wr(16'h4801, {4'h0, bank, ln});
		sq.push_back({~(!bank && ln == LN_GCLK && steer[STEER_OPT_BIT]), bank ? s : 8'hFF, bank ? 8'hFF : s});
		if (!bank && ln == LN_STEER) steer = pa;
		phase(1'b1);
		phase(1'b0);
		phase(1'b1);
		phase(1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// watchers take the oldest note when a read or a strobe appears
	always @(posedge clk) begin
		if (cpu_data_oe === 1'b1 && oe_q !== 1'b1) chk_rd(cpu_data_out, rq.size() ? rq.pop_front() : 8'hXX);
		if ({dec0_n, dec1_n} !== 16'hFFFF && st_idle)
			chk({option_shift_clock_n, dec0_n, dec1_n}, sq.size() ? sq.pop_front() : 17'hX);
		oe_q <= cpu_data_oe;
		st_idle <= ({dec0_n, dec1_n} === 16'hFFFF);
	end
	// hang guard, well above the expected run length
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] d, e, sb;
		logic [31:0] lamps;
		seed = 32'hec1dc0c0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		chk({irq_b_n, option_shift_clock_n, dec0_n, dec1_n}, {2'b11, 16'hFFFF});
		mux_lo_in <= 28'($random(seed));
		mux_hi_in <= 12'($random(seed));
		cfg_switch <= 8'($random(seed));
		@(posedge clk);
		for (int g = 0; g < 8; g++) begin
			e[3:0] = (g == 7) ? cfg_switch[3:0] : mux_lo_in[4 * g +: 4];
			e[7:4] = (g[1:0] == 2'h3) ? cfg_switch[7:4] : mux_hi_in[4 * g[1:0] +: 4];
			rd(16'h6000 | 16'(g), e);
		end
		rd(16'h4802, 8'h01);
		repeat (3) @(posedge clk);
		chk({irq_a_n, irq_b_n}, 2'b11);
		bus_int <= 1'b1;
		repeat (3) @(posedge clk);
		chk({irq_a_n, irq_b_n}, 2'b10);
		rd(16'h4802, 8'h02);
		bus_int <= 1'b0;
		rd(16'h4802, 8'h02);
		repeat (3) @(posedge clk);
		chk(irq_b_n, 1'b1);
		wr(16'h0010, 8'($random(seed)));
		wr(16'h1010, 8'($random(seed)));
		d = 8'($random(seed));
		wr(16'h4800, d);
		wr(16'h4000, ~d); // address 11 low: adapter must ignore it
		fire(1'b0, LN_LOOP);
		chk(loop_latch, d);
		wr(16'h4800, 8'h41);
		fire(1'b0, LN_STEER);
		chk(steer_latch, 8'h41);
		fire(1'b0, LN_GCLK);
		d = 8'($random(seed));
		wr(16'h4800, d);
		fire(1'b0, LN_DISP);
		chk({disp_segments, disp_scan}, {d, 19'h1});
		wr(16'h4800, 8'h00);
		fire(1'b0, LN_STEER);
		d = 8'($random(seed));
		wr(16'h4800, d);
		fire(1'b0, LN_DISP);
		chk({disp_segments, disp_scan}, {d, 19'h2});
		fire(1'b0, LN_GCLK);
		fire(1'b0, LN_FIV);
		fire(1'b0, LN_FDC);
		for (int k = 0; k < 4; k++) begin
			d = 8'($random(seed));
			lamps[8 * k +: 8] = d;
			wr(16'h4800, d);
			fire(1'b1, LN_IND_FIRST + 3'(k));
		end
		wr(16'h4800, 8'h5A);
		fire(1'b1, 3'h0);
		chk(indicator_lamps, lamps);
		// open the option clock gate so the shift clocks between bits reach the far end
		wr(16'h4800, 8'h40);
		fire(1'b0, LN_STEER);
		d = 8'($random(seed));
		wr(16'h4800, d);
		fire(1'b0, LN_LOAD);
		// each bit shows only after its own shift pulse
		for (int i = 0; i < 8; i++) begin
			fire(1'b0, LN_SHIFT);
			sb[7 - i] = serial_out;
			fire(1'b0, LN_GCLK);
		end
		chk(sb, d);
		rd(16'h4800, d);
		rd(16'h4801, {5'h00, LN_GCLK});
		repeat (TP + 20) @(posedge clk);
		chk(irq_a_n, 1'b0);
		chk(32'(sq.size() + rq.size()), 32'h0);
		results();
	end
endmodule
